// File: design/ktr_pkg.sv
// package for the link training register bank: offsets, fields, resets
// assumes word addressing on the plain register port
`default_nettype none
package ktr_pkg;
  localparam int ADDR_W = 8;
  // register word addresses
  localparam logic [7:0] OFS_FRAME = 8'hd4;
  localparam logic [7:0] OFS_APPLIED = 8'hd5;
  localparam logic [7:0] OFS_LIMITS = 8'hd6;
  localparam logic [7:0] OFS_CTRL = 8'hd7;
  // training frame word fields
  localparam int FR_LPUPD_LO = 16;
  localparam int FR_LPINIT = 22;
  localparam int FR_PRESET = 23;
  localparam int FR_LPSTAT_LO = 24;
  localparam int FR_RXREADY = 30;
  // applied settings fields
  localparam int AP_SWING_LO = 0;
  localparam int AP_POST_LO = 8;
  localparam int AP_PRE_LO = 16;
  localparam int AP_RX_LINEAR_EQUALIZER_LO = 20;
  localparam int AP_CTLEM_LO = 24;
  localparam int AP_DFEM_LO = 26;
  // override fields
  localparam int OV_MAX_LO = 0;
  localparam int OV_MAX_EN = 6;
  localparam int OV_MIN_LO = 8;
  localparam int OV_MIN_EN = 14;
  localparam int OV_POST_LO = 16;
  localparam int OV_POST_EN = 21;
  localparam int OV_PRE_LO = 24;
  localparam int OV_PRE_EN = 28;
  // control word: bit 0 training enable
  localparam int CT_TRAIN_EN = 0;
  localparam logic CTRL_RESET = 1'b1;
  localparam logic [31:0] LIMITS_RESET = 32'h0000_0000;
  localparam logic [31:0] LIMITS_MASK = 32'h1f3f_7f7f;
  // partner status encoding
  localparam logic [1:0] ST_MAX = 2'b11;
  localparam logic [1:0] ST_MIN = 2'b01;
  localparam logic [1:0] ST_UPD = 2'b10;
  localparam logic [1:0] ST_NONE = 2'b00;
endpackage
`default_nettype wire

// File: design/ktr_limit_sel.sv
// one limit selector: override value or compile-time limit
// assumes enable and value come from the same clock domain
`default_nettype none
module ktr_limit_sel #(
  parameter int W = 6
) (
  input wire logic en,
  input wire logic [W-1:0] ovrd,
  input wire logic [W-1:0] dflt,
  output logic [W-1:0] lim
);
  // stored override is ignored whenever its enable is clear
  assign lim = en ? ovrd : dflt;
endmodule
`default_nettype wire

// File: design/ktr_regs.sv
// link training register bank: partner frame fields, applied settings,
// transmit limit overrides for max swing, min swing, post and pre tap; preset main tap follows the max override
// assumes train_logic and receive_equalization inputs share clk
//
// The address-and-strobe port was left to the implementer.
`default_nettype none
module ktr_regs #(
  parameter logic [5:0] MAX_SWING_LIMIT = 6'h3c,
  parameter logic [5:0] MIN_SWING_LIMIT = 6'h09,
  parameter logic [4:0] POST_TAP_LIMIT = 5'h19,
  parameter logic [3:0] PRE_TAP_LIMIT = 4'h0f,
  parameter logic [5:0] PRESET_MAIN_TAP = 6'h3c
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [ktr_pkg::ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // partner frame as decoded by train_logic
  input wire logic frame_valid,
  input wire logic [5:0] frame_update,
  input wire logic frame_init,
  input wire logic frame_preset,
  input wire logic [5:0] frame_status,
  input wire logic frame_rx_ready,
  // settings issued to the reconfiguration logic
  input wire logic swing_valid,
  input wire logic [5:0] swing_val,
  input wire logic post_valid,
  input wire logic [4:0] post_val,
  input wire logic pre_valid,
  input wire logic [3:0] pre_val,
  input wire logic rx_linear_equalizer_valid,
  input wire logic [3:0] rx_linear_equalizer_val,
  input wire logic rx_linear_equalizer_mode_valid,
  input wire logic [1:0] rx_linear_equalizer_mode_val,
  input wire logic dfe_mode_valid,
  input wire logic [1:0] dfe_mode_val,
  // to train_logic
  output logic train_en,
  output logic [5:0] lp_update,
  output logic lp_init,
  output logic tx_preset,
  output logic [5:0] max_swing_limit,
  output logic [5:0] min_swing_limit,
  output logic [4:0] post_tap_limit,
  output logic [3:0] pre_tap_limit,
  output logic [5:0] preset_main_tap
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [5:0] upd;
  logic init;
  logic preset;
  logic [5:0] lpstat;
  logic rxready;
  logic [31:0] applied;
  logic [31:0] limits;
  logic wr_frame;
  logic wr_limits;
  logic wr_ctrl;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  assign wr_frame = wr && hit(addr, ktr_pkg::OFS_FRAME);
  assign wr_limits = wr && hit(addr, ktr_pkg::OFS_LIMITS);
  assign wr_ctrl = wr && hit(addr, ktr_pkg::OFS_CTRL);

  // ---------------------------------------------------------------
  // control
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      train_en <= ktr_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      train_en <= wdata[ktr_pkg::CT_TRAIN_EN];
    end
  end

  // ---------------------------------------------------------------
  // partner frame fields
  // ---------------------------------------------------------------
  // training logic owns the fields while enabled; software only after
  // it clears the enable, so the two never race for the same bits
  always_ff @(posedge clk) begin
    if (!rstn) begin
      upd <= 6'h00;
      init <= 1'b0;
      preset <= 1'b0;
    end else if (train_en) begin
      if (frame_valid) begin
        upd <= frame_update;
        init <= frame_init;
        preset <= frame_preset;
      end
    end else if (wr_frame) begin
      upd <= wdata[ktr_pkg::FR_LPUPD_LO +: 6];
      init <= wdata[ktr_pkg::FR_LPINIT];
      preset <= wdata[ktr_pkg::FR_PRESET];
    end
  end

  // status fields are never writable
  always_ff @(posedge clk) begin
    if (!rstn) begin
      lpstat <= {3{ktr_pkg::ST_NONE}};
      rxready <= 1'b0;
    end else if (frame_valid) begin
      lpstat <= frame_status;
      rxready <= frame_rx_ready;
    end
  end

  assign lp_update = upd;
  assign lp_init = init;
  assign tx_preset = preset;

  // ---------------------------------------------------------------
  // applied settings capture
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      applied <= 32'h0000_0000;
    end else begin
      if (swing_valid) begin
        applied[ktr_pkg::AP_SWING_LO +: 6] <= swing_val;
      end
      if (post_valid) begin
        applied[ktr_pkg::AP_POST_LO +: 5] <= post_val;
      end
      if (pre_valid) begin
        applied[ktr_pkg::AP_PRE_LO +: 4] <= pre_val;
      end
      if (rx_linear_equalizer_valid) begin
        applied[ktr_pkg::AP_RX_LINEAR_EQUALIZER_LO +: 4] <= rx_linear_equalizer_val;
      end
      if (rx_linear_equalizer_mode_valid) begin
        applied[ktr_pkg::AP_CTLEM_LO +: 2] <= rx_linear_equalizer_mode_val;
      end
      if (dfe_mode_valid) begin
        applied[ktr_pkg::AP_DFEM_LO +: 2] <= dfe_mode_val;
      end
    end
  end

  // ---------------------------------------------------------------
  // limit overrides
  // ---------------------------------------------------------------
  // hardware does not check the programmed ranges; bad values are
  // software's problem
  always_ff @(posedge clk) begin
    if (!rstn) begin
      limits <= ktr_pkg::LIMITS_RESET;
    end else if (wr_limits) begin
      limits <= wdata & ktr_pkg::LIMITS_MASK;
    end
  end

  ktr_limit_sel #(.W(6)) u_max (
    .en(limits[ktr_pkg::OV_MAX_EN]),
    .ovrd(limits[ktr_pkg::OV_MAX_LO +: 6]),
    .dflt(MAX_SWING_LIMIT),
    .lim(max_swing_limit)
  );
  ktr_limit_sel #(.W(6)) u_pmain (
    .en(limits[ktr_pkg::OV_MAX_EN]),
    .ovrd(limits[ktr_pkg::OV_MAX_LO +: 6]),
    .dflt(PRESET_MAIN_TAP),
    .lim(preset_main_tap)
  );
  ktr_limit_sel #(.W(6)) u_min (
    .en(limits[ktr_pkg::OV_MIN_EN]),
    .ovrd(limits[ktr_pkg::OV_MIN_LO +: 6]),
    .dflt(MIN_SWING_LIMIT),
    .lim(min_swing_limit)
  );
  ktr_limit_sel #(.W(5)) u_post (
    .en(limits[ktr_pkg::OV_POST_EN]),
    .ovrd(limits[ktr_pkg::OV_POST_LO +: 5]),
    .dflt(POST_TAP_LIMIT),
    .lim(post_tap_limit)
  );
  ktr_limit_sel #(.W(4)) u_pre (
    .en(limits[ktr_pkg::OV_PRE_EN]),
    .ovrd(limits[ktr_pkg::OV_PRE_LO +: 4]),
    .dflt(PRE_TAP_LIMIT),
    .lim(pre_tap_limit)
  );

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata <= 32'h0000_0000;
    end else if (rd) begin
      case (addr)
        ktr_pkg::OFS_FRAME: begin
          rdata <= {1'b0, rxready, lpstat, preset, init, upd, 16'h0000};
        end
        ktr_pkg::OFS_APPLIED: rdata <= applied;
        ktr_pkg::OFS_LIMITS: rdata <= limits;
        ktr_pkg::OFS_CTRL: rdata <= {31'h0000_0000, train_en};
        default: rdata <= 32'h0000_0000;
      endcase
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  preset_follow_a: assert property (
    @(posedge clk) disable iff (!rstn)
    (train_en && frame_valid) |=> tx_preset == $past(frame_preset))
    else $error("preset not taken from frame");
  locked_frame_a: assert property (
    @(posedge clk) disable iff (!rstn)
    (train_en && !frame_valid) |=> $stable(lp_update))
    else $error("partner update changed while locked");
  locked_write_a: assert property (
    @(posedge clk) disable iff (!rstn)
    (train_en && wr_frame && !frame_valid)
    |=> $stable(lp_update) && $stable(lp_init) && $stable(tx_preset))
    else $error("partner fields written while locked");
  open_write_a: assert property (
    @(posedge clk) disable iff (!rstn)
    (!train_en && wr_frame)
    |=> lp_update == $past(wdata[ktr_pkg::FR_LPUPD_LO +: 6])
    && tx_preset == $past(wdata[ktr_pkg::FR_PRESET]))
    else $error("partner fields not writable when open");
  status_rd_a: assert property (
    @(posedge clk) disable iff (!rstn)
    (frame_valid ##1 (rd && addr == ktr_pkg::OFS_FRAME && !frame_valid))
    |=> rdata[ktr_pkg::FR_LPSTAT_LO +: 6] == $past(frame_status, 2))
    else $error("partner status readback wrong");
  status_hold_a: assert property (
    @(posedge clk) disable iff (!rstn)
    !frame_valid |=> $stable(lpstat))
    else $error("partner status changed without frame");
  ready_rd_a: assert property (
    @(posedge clk) disable iff (!rstn)
    (frame_valid ##1 (rd && addr == ktr_pkg::OFS_FRAME && !frame_valid))
    |=> rdata[ktr_pkg::FR_RXREADY] == $past(frame_rx_ready, 2))
    else $error("partner ready readback wrong");
  ready_hold_a: assert property (
    @(posedge clk) disable iff (!rstn)
    !frame_valid |=> $stable(rxready))
    else $error("partner ready changed without frame");

  // ---------------------------------------------------------------
  // applied settings checks
  // ---------------------------------------------------------------
  swing_cap_a: assert property (
    @(posedge clk) disable iff (!rstn)
    swing_valid |=> applied[ktr_pkg::AP_SWING_LO +: 6] == $past(swing_val))
    else $error("swing not captured");
  applied_rd_a: assert property (
    @(posedge clk) disable iff (!rstn)
    (rd && addr == ktr_pkg::OFS_APPLIED) |=> rdata == $past(applied))
    else $error("applied word readback wrong");
  post_cap_a: assert property (
    @(posedge clk) disable iff (!rstn)
    post_valid |=> applied[ktr_pkg::AP_POST_LO +: 5] == $past(post_val))
    else $error("post tap not captured");
  pre_cap_a: assert property (
    @(posedge clk) disable iff (!rstn)
    pre_valid |=> applied[ktr_pkg::AP_PRE_LO +: 4] == $past(pre_val))
    else $error("pre tap not captured");
  rx_linear_equalizer_cap_a: assert property (
    @(posedge clk) disable iff (!rstn)
    rx_linear_equalizer_valid |=> applied[ktr_pkg::AP_RX_LINEAR_EQUALIZER_LO +: 4] == $past(rx_linear_equalizer_val))
    else $error("linear eq setting not captured");
  rx_linear_equalizer_mode_cap_a: assert property (
    @(posedge clk) disable iff (!rstn)
    rx_linear_equalizer_mode_valid
    |=> applied[ktr_pkg::AP_CTLEM_LO +: 2] == $past(rx_linear_equalizer_mode_val))
    else $error("linear eq mode not captured");
  dfe_cap_a: assert property (
    @(posedge clk) disable iff (!rstn)
    dfe_mode_valid
    |=> applied[ktr_pkg::AP_DFEM_LO +: 2] == $past(dfe_mode_val))
    else $error("feedback mode not captured");

  // ---------------------------------------------------------------
  // limit override checks
  // ---------------------------------------------------------------
  max_ovrd_a: assert property (
    @(posedge clk) disable iff (!rstn)
    (wr_limits && wdata[ktr_pkg::OV_MAX_EN])
    |=> max_swing_limit == $past(wdata[ktr_pkg::OV_MAX_LO +: 6])
    && preset_main_tap == $past(wdata[ktr_pkg::OV_MAX_LO +: 6]))
    else $error("max swing override not applied");
  min_ovrd_a: assert property (
    @(posedge clk) disable iff (!rstn)
    (wr_limits && wdata[ktr_pkg::OV_MIN_EN])
    |=> min_swing_limit == $past(wdata[ktr_pkg::OV_MIN_LO +: 6]))
    else $error("min swing override not applied");
  post_ovrd_a: assert property (
    @(posedge clk) disable iff (!rstn)
    (wr_limits && wdata[ktr_pkg::OV_POST_EN])
    |=> post_tap_limit == $past(wdata[ktr_pkg::OV_POST_LO +: 5]))
    else $error("post tap override not applied");
  pre_ovrd_a: assert property (
    @(posedge clk) disable iff (!rstn)
    (wr_limits && wdata[ktr_pkg::OV_PRE_EN])
    |=> pre_tap_limit == $past(wdata[ktr_pkg::OV_PRE_LO +: 4]))
    else $error("pre tap override not applied");
  max_dflt_a: assert property (
    @(posedge clk) disable iff (!rstn)
    (wr_limits && !wdata[ktr_pkg::OV_MAX_EN])
    |=> max_swing_limit == MAX_SWING_LIMIT
    && preset_main_tap == PRESET_MAIN_TAP)
    else $error("max swing default not used");
  min_dflt_a: assert property (
    @(posedge clk) disable iff (!rstn)
    (wr_limits && !wdata[ktr_pkg::OV_MIN_EN])
    |=> min_swing_limit == MIN_SWING_LIMIT)
    else $error("min swing default not used");
  post_dflt_a: assert property (
    @(posedge clk) disable iff (!rstn)
    (wr_limits && !wdata[ktr_pkg::OV_POST_EN])
    |=> post_tap_limit == POST_TAP_LIMIT)
    else $error("post tap default not used");
  pre_dflt_a: assert property (
    @(posedge clk) disable iff (!rstn)
    (wr_limits && !wdata[ktr_pkg::OV_PRE_EN])
    |=> pre_tap_limit == PRE_TAP_LIMIT)
    else $error("pre tap default not used");
endmodule
`default_nettype wire

// File: bench/ktr_partner.sv
// far-side model: the training logic feeding frames and applied settings
// assumes single clk; data lines show garbage outside their valid pulse
`default_nettype none
module ktr_partner (
  input wire logic clk,
  output logic fv,
  output logic [5:0] fu,
  output logic fi,
  output logic fp,
  output logic [5:0] fs,
  output logic fr,
  output logic sv,
  output logic [5:0] sw,
  output logic [4:0] po,
  output logic [3:0] pr,
  output logic [3:0] ct,
  output logic [1:0] cm,
  output logic [1:0] dm
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {fv, fu, fi, fp, fs, fr, sv, sw, po, pr, ct, cm, dm} = '0;
  end
  // data inverted after the pulse so a late capture is caught
  task automatic frame(input logic [5:0] u, input logic i, p,
                       input logic [5:0] s, input logic r);
    @(posedge clk);
    {fv, fu, fi, fp, fs, fr} <= {1'b1, u, i, p, s, r};
    @(posedge clk);
    {fv, fu, fi, fp, fs, fr} <= {1'b0, ~u, ~i, ~p, ~s, ~r};
  endtask
  task automatic sets(input logic [22:0] v);
    @(posedge clk);
    sv <= 1'b1;
    {sw, po, pr, ct, cm, dm} <= v;
    @(posedge clk);
    sv <= 1'b0;
    {sw, po, pr, ct, cm, dm} <= ~v;
  endtask
endmodule
`default_nettype wire

// File: bench/kr_link_training_regs_test.sv
// bench for the training register bank: bus tasks, partner, checks
// assumes default limit parameters of the bank
`default_nettype none
module kr_link_training_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rstn, wr, rd, fv, fi, fp, fr, sv, te, li, tp;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic [5:0] fu, fs, sw, lu, mx, mn, pm;
  logic [4:0] po, pl;
  logic [3:0] pr, ct, ql;
  logic [1:0] cm, dm;
  int fail_count = 0;
  int total_checks = 0;
  ktr_partner p (.clk(clk), .fv(fv), .fu(fu), .fi(fi), .fp(fp), .fs(fs),
    .fr(fr), .sv(sv), .sw(sw), .po(po), .pr(pr), .ct(ct), .cm(cm), .dm(dm));
  ktr_regs uut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .frame_valid(fv), .frame_update(fu),
    .frame_init(fi), .frame_preset(fp), .frame_status(fs),
    .frame_rx_ready(fr), .swing_valid(sv), .swing_val(sw), .post_valid(sv),
    .post_val(po), .pre_valid(sv), .pre_val(pr), .rx_linear_equalizer_valid(sv),
    .rx_linear_equalizer_val(ct), .rx_linear_equalizer_mode_valid(sv), .rx_linear_equalizer_mode_val(cm),
    .dfe_mode_valid(sv), .dfe_mode_val(dm), .train_en(te), .lp_update(lu),
    .lp_init(li), .tx_preset(tp), .max_swing_limit(mx),
    .min_swing_limit(mn), .post_tap_limit(pl), .pre_tap_limit(ql),
    .preset_main_tap(pm));
  // --------------------------------
  // bus and check tasks
  // --------------------------------
  task automatic chk(input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {wr, addr, wdata} <= {1'b1, a, d};
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    {rd, addr} <= {1'b1, a};
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic lims(input logic [20:0] e);
    #1 chk({11'h0, mx, mn, pl, ql}, {11'h0, e});
  endtask
  // --------------------------------
  // scenarios
  // --------------------------------
  task automatic t_reset();
    lims({6'h3c, 6'h09, 5'h19, 4'hf});
    chk({31'h0, te}, 32'h0000_0001);
    chk({26'h0, pm}, 32'h0000_003c);
    rd_reg(8'hd5, 32'h0000_0000);
    rd_reg(8'h00, 32'h0000_0000);
  endtask
  // read issued in the cycle right after the frame pulse
  task automatic t_frame_read();
    fork
      p.frame(6'h00, 1'b0, 1'b0, 6'h27, 1'b0);
      begin
        @(posedge clk);
        rd_reg(8'hd4, 32'h2700_0000);
      end
    join
  endtask
  task automatic t_frame();
    p.frame(6'h15, 1'b1, 1'b1, 6'h36, 1'b1);
    @(posedge clk);
    #1 chk({31'h0, tp}, 32'h0000_0001);
    rd_reg(8'hd4, 32'h76d5_0000);
    p.frame(6'h00, 1'b0, 1'b0, 6'h00, 1'b0);
    @(posedge clk);
    #1 chk({31'h0, tp}, 32'h0000_0000);
    rd_reg(8'hd4, 32'h0000_0000);
    p.frame(6'h00, 1'b0, 1'b0, 6'h1c, 1'b1);
    rd_reg(8'hd4, 32'h5c00_0000);
  endtask
  task automatic t_write_guard();
    wr_reg(8'hd4, 32'h00ff_0000);
    rd_reg(8'hd4, 32'h5c00_0000);
    wr_reg(8'hd7, 32'h0000_0000);
    wr_reg(8'hd4, 32'h00ea_0000);
    rd_reg(8'hd4, 32'h5cea_0000);
    chk({24'h0, tp, li, lu}, 32'h0000_00ea);
    wr_reg(8'hd7, 32'h0000_0001);
  endtask
  task automatic t_applied();
    p.sets({6'h2a, 5'h15, 4'h9, 4'h6, 2'b10, 2'b01});
    rd_reg(8'hd5, 32'h0669_152a);
    wr_reg(8'hd5, 32'hffff_ffff);
    rd_reg(8'hd5, 32'h0669_152a);
  endtask
  task automatic t_overrides();
    // values kept inside the documented safe ranges
    wr_reg(8'hd6, 32'h1c3b_4a7e);
    lims({6'h3e, 6'h0a, 5'h1b, 4'hc});
    chk({26'h0, pm}, 32'h0000_003e);
    rd_reg(8'hd6, 32'h1c3b_4a7e);
    wr_reg(8'hd6, 32'hef1f_3f3f);
    lims({6'h3c, 6'h09, 5'h19, 4'hf});
    chk({26'h0, pm}, 32'h0000_003c);
    rd_reg(8'hd6, 32'h0f1f_3f3f);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    close_out();
  end
  initial begin
    {rstn, wr, rd, addr, wdata} = '0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_frame_read();
    t_frame();
    t_write_guard();
    t_applied();
    t_overrides();
    close_out();
  end
endmodule
`default_nettype wire
